// file: shared/aecd_regs.svh
`ifndef AECD_REGS_SVH
`define AECD_REGS_SVH

// Host-side offsets, 3-bit I/O window.
`define AECD_OFF_DATA0     3'h0
`define AECD_OFF_DATA3     3'h3
`define AECD_OFF_CMD_STAT  3'h4
`define AECD_OFF_BYTE_CTL  3'h5

// Byte lane numbers, 2-bit.
`define AECD_LANE0         2'h0
`define AECD_LANE3         2'h3

// Status bit positions.
`define AECD_ST_OBF        0
`define AECD_ST_IBF        1
`define AECD_ST_CMD        3

// Reset values.
`define AECD_BYTE_RST      8'h00
`define AECD_STAT_RST      8'h00
`define AECD_ZERO_BYTE     8'h00

`endif

// file: shared/aecd_pkg.sv
package aecd_pkg;

    // One host I/O access, taken in the cycle its strobe is high.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } aecd_host_req_t;

    // One controller-side access to its own aliases.
    typedef struct packed {
        logic       data_wr;
        logic [1:0] data_idx;
        logic [7:0] data_val;
        logic       stat_wr;
        logic [7:0] stat_val;
        logic       ibf_clr;
        logic       four_byte;
    } aecd_ctl_req_t;

endpackage

// file: src/aecd_byte_bank.sv
`timescale 1ns/100ps
`default_nettype none
`include "aecd_regs.svh"

module aecd_byte_bank
    import aecd_pkg::*;
(
    input  wire logic       clock,    // System clock.
    input  wire logic       sys_rst,  // Synchronous reset.
    input  wire logic       wr_en,    // Write strobe.
    input  wire logic [1:0] wr_idx,   // Byte lane written.
    input  wire logic [7:0] wr_val,   // Byte written.
    input  wire logic [1:0] rd_idx,   // Byte lane read.
    output logic [31:0]     all_q,    // Whole word, registered.
    output logic [7:0]      rd_q      // Selected byte, combinational.
);

    // ==========================================================
    // Four byte registers.
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_byte
            always_ff @(posedge clock) begin
                if (sys_rst)
                    all_q[8*g +: 8] <= `AECD_BYTE_RST;
                else if (wr_en && wr_idx == 2'(g))
                    all_q[8*g +: 8] <= wr_val;
            end
        end
    endgenerate

    assign rd_q = all_q[8*rd_idx +: 8];

endmodule
`default_nettype wire

// file: src/aecd_status_reg.sv
`timescale 1ns/100ps
`default_nettype none
`include "aecd_regs.svh"

module aecd_status_reg
    import aecd_pkg::*;
(
    input  wire logic       clock,    // System clock.
    input  wire logic       sys_rst,  // Synchronous reset.
    input  wire logic       sw_wr,    // Controller writes whole status.
    input  wire logic [7:0] sw_val,   // Value written by controller.
    input  wire logic       set_ibf,  // Input-full set event.
    input  wire logic       clr_ibf,  // Input-full clear event.
    input  wire logic       set_obf,  // Output-full set event.
    input  wire logic       clr_obf,  // Output-full clear event.
    input  wire logic       set_cmd,  // Command flag set event.
    input  wire logic       clr_cmd,  // Command flag clear event.
    output logic [7:0]      stat      // Status byte, registered.
);

    logic [7:0] base;
    logic [7:0] next_stat;

    // ==========================================================
    // Hardware events override a same-cycle controller write; set wins over clear.
    always_comb begin
        base = sw_wr ? sw_val : stat;
        next_stat = base;
        next_stat[`AECD_ST_IBF] = set_ibf | (base[`AECD_ST_IBF] & ~clr_ibf);
        next_stat[`AECD_ST_OBF] = set_obf | (base[`AECD_ST_OBF] & ~clr_obf);
        next_stat[`AECD_ST_CMD] = set_cmd | (base[`AECD_ST_CMD] & ~clr_cmd);
    end

    always_ff @(posedge clock) begin
        if (sys_rst)
            stat <= `AECD_STAT_RST;
        else
            stat <= next_stat;
    end

endmodule
`default_nettype wire

// file: src/aecd_host_port.sv
// Notes on behaviour
// RL1: host data writes land in host_to_controller_data
// RL2: host data reads return controller_to_host_data
// RL3: host should access bytes low to high
// RL4: any data write clears command flag
// RL5: legacy byte0 write sets input_full_flag
// RL6: legacy byte0 read clears output_full_flag
// RL7: legacy bytes 1-3 writes accepted, discarded
// RL8: legacy bytes 1-3 reads return zero
// RL9: legacy bytes 1-3 leave full flags alone
// RL10: four-byte byte3 write sets input_full_flag
// RL11: four-byte byte3 read clears output_full_flag
// RL12: eSPI instance 0 forced to legacy mode
// RL13: data bytes 8-bit, reset to zero
// RL14: command write goes into data byte 0
// RL15: command write sets command and input-full
// RL16: status read-only, mirrors controller status
// RL17: bit 6 is firmware system-management query flag
// RL18: block raises no interrupts, flags only
// RL19: bit 3 is hardware command flag
// RL20: controller read clears input_full_flag
// RL21: bit 5 is firmware OS query flag
// RL22: data byte 0 at offset zero
// RL23: controller write of last byte sets output_full_flag
// RL24: host flag updates land next edge
`timescale 1ns/100ps
`default_nettype none
`include "aecd_regs.svh"

module aecd_host_port
    import aecd_pkg::*;
#(
    parameter bit INSTANCE_ZERO = 1'b0
)
(
    input  wire logic           clock,        // System clock, 50 MHz.
    input  wire logic           sys_rst,      // Synchronous reset, active high.
    input  wire aecd_host_req_t host_req,     // Host I/O access strobe and data.
    output logic [7:0]          host_rdata,   // Host read data, combinational.
    input  wire logic           espi_mode,    // Host link runs eSPI.
    input  wire aecd_ctl_req_t  ctl_req,      // Controller-side accesses.
    output logic [31:0]         h2c_word,     // Host-to-controller bytes.
    output logic [31:0]         c2h_word,     // Controller-to-host bytes.
    output logic [7:0]          status,       // Status byte as both sides see it.
    output logic                four_byte_on  // Effective four-byte mode.
);

    // ==========================================================
    // Access decode.
    logic       four_byte_q;
    wire        is_data   = host_req.addr[2] == 1'b0;
    wire  [1:0] lane      = host_req.addr[1:0];
    wire        data_wr   = host_req.wr && is_data;
    wire        data_rd   = host_req.rd && is_data;
    wire        cmd_wr    = host_req.wr && host_req.addr == `AECD_OFF_CMD_STAT;
    wire  [1:0] last_lane = four_byte_on ? `AECD_LANE3 : `AECD_LANE0;
    wire        lane_live = four_byte_on || lane == `AECD_LANE0;
    wire        lane_last = lane == last_lane;

    assign four_byte_on = four_byte_q && !(INSTANCE_ZERO && espi_mode);   // [RL12]

    always_ff @(posedge clock) begin
        if (sys_rst)
            four_byte_q <= 1'b0;
        else
            four_byte_q <= ctl_req.four_byte;
    end

    // ==========================================================
    // Host-to-controller bytes; command port aliases byte 0.
    wire        h2c_wr  = (data_wr && lane_live) || cmd_wr;                // [RL1] [RL7]
    wire  [1:0] h2c_idx = cmd_wr ? `AECD_LANE0 : lane;                     // [RL14] [RL22]

    aecd_byte_bank u_h2c (                                                 // [RL13]
        .clock   (clock),
        .sys_rst (sys_rst),
        .wr_en   (h2c_wr),
        .wr_idx  (h2c_idx),
        .wr_val  (host_req.wdata),
        .rd_idx  (lane),
        .all_q   (h2c_word),
        .rd_q    ()
    );

    // ==========================================================
    // Controller-to-host bytes.
    logic [7:0] c2h_byte;

    aecd_byte_bank u_c2h (
        .clock   (clock),
        .sys_rst (sys_rst),
        .wr_en   (ctl_req.data_wr),
        .wr_idx  (ctl_req.data_idx),
        .wr_val  (ctl_req.data_val),
        .rd_idx  (lane),
        .all_q   (c2h_word),
        .rd_q    (c2h_byte)
    );

    // ==========================================================
    // Host read data: data lanes, status, reads of unused lanes as zero.
    wire  [7:0] data_rd_val = lane_live ? c2h_byte : `AECD_ZERO_BYTE;      // [RL2] [RL8]
    wire        stat_rd     = host_req.addr == `AECD_OFF_CMD_STAT;
    wire        ctl_rd      = host_req.addr == `AECD_OFF_BYTE_CTL;

    assign host_rdata = is_data ? data_rd_val
                      : stat_rd ? status                                   // [RL16]
                      : ctl_rd  ? {7'h00, four_byte_on}
                      : `AECD_ZERO_BYTE;

    // ==========================================================
    // Status flags; bits 5, 6, 7 and 4, 2 are firmware-owned, no interrupt out.
    wire set_ibf = cmd_wr || (data_wr && lane_live && lane_last);          // [RL5] [RL10] [RL15] [RL9]
    wire clr_obf = data_rd && lane_live && lane_last;                      // [RL6] [RL11] [RL9]
    wire set_obf = ctl_req.data_wr && ctl_req.data_idx == last_lane;      // [RL23]

    aecd_status_reg u_stat (                                               // [RL24] [RL18]
        .clock   (clock),
        .sys_rst (sys_rst),
        .sw_wr   (ctl_req.stat_wr),                                        // [RL17] [RL21]
        .sw_val  (ctl_req.stat_val),
        .set_ibf (set_ibf),
        .clr_ibf (ctl_req.ibf_clr),                                        // [RL20]
        .set_obf (set_obf),
        .clr_obf (clr_obf),
        .set_cmd (cmd_wr),                                                 // [RL15] [RL19]
        .clr_cmd (data_wr),                                                // [RL4]
        .stat    (status)
    );

endmodule
`default_nettype wire

// file: test/aecd_checker.sv
`timescale 1ns/100ps
`default_nettype none
module aecd_checker
    import aecd_pkg::*;
#(parameter bit INSTANCE_ZERO = 1'b0)
(
    input wire logic           clock,        // Clock.
    input wire logic           sys_rst,      // Reset.
    input wire aecd_host_req_t host_req,     // Host access.
    input wire logic [7:0]     host_rdata,   // Read data.
    input wire logic           espi_mode,    // Link mode.
    input wire aecd_ctl_req_t  ctl_req,      // Controller access.
    input wire logic [31:0]    h2c_word,     // Host bytes.
    input wire logic [31:0]    c2h_word,     // Controller bytes.
    input wire logic [7:0]     status,       // Status.
    input wire logic           four_byte_on  // Mode.
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire logic       w  = host_req.wr;
    wire logic       r  = host_req.rd;
    wire logic [2:0] a  = host_req.addr;
    wire logic       fb = four_byte_on;
    wire logic       cq = ctl_req.data_wr | ctl_req.stat_wr | ctl_req.ibf_clr;
    property p_cmd;
        w && a == 3'h4 |=> status[3] && status[1] && h2c_word[7:0] == $past(host_req.wdata);
    endproperty
    a_cmd: assert property (p_cmd) else $error("command write");
    property p_dclr; w && a < 3'h4 |=> !status[3]; endproperty
    a_dclr: assert property (p_dclr) else $error("data write kept flag");
    property p_lw0; w && a == 3'h0 && !fb |=> status[1]; endproperty
    a_lw0: assert property (p_lw0) else $error("byte0 write");
    property p_lr0; r && a == 3'h0 && !fb && !ctl_req.data_wr |=> !status[0]; endproperty
    a_lr0: assert property (p_lr0) else $error("byte0 read");
    property p_lhi;
        (w || r) && a inside {[3'h1:3'h3]} && !fb && !cq
            |=> $stable(status[1:0]) && $stable(h2c_word[31:8]);
    endproperty
    a_lhi: assert property (p_lhi) else $error("upper byte effect");
    property p_lz; r && a inside {[3'h1:3'h3]} && !fb |-> host_rdata == 8'h00; endproperty
    a_lz: assert property (p_lz) else $error("upper byte read");
    property p_fw3; w && a == 3'h3 && fb |=> status[1] && h2c_word[31:24] == $past(host_req.wdata);
    endproperty
    a_fw3: assert property (p_fw3) else $error("byte3 write");
    property p_fr3; r && a == 3'h3 && fb && !ctl_req.data_wr |=> !status[0]; endproperty
    a_fr3: assert property (p_fr3) else $error("byte3 read");
    property p_rd0; r && a == 3'h0 |-> host_rdata == c2h_word[7:0]; endproperty
    a_rd0: assert property (p_rd0) else $error("byte0 data");
    property p_espi; espi_mode[*2] |-> !INSTANCE_ZERO || !fb; endproperty
    a_espi: assert property (p_espi) else $error("four byte in link mode");
endmodule
bind aecd_host_port aecd_checker #(.INSTANCE_ZERO(INSTANCE_ZERO)) chk (.clock(clock),
    .sys_rst(sys_rst), .host_req(host_req), .host_rdata(host_rdata), .espi_mode(espi_mode),
    .ctl_req(ctl_req), .h2c_word(h2c_word), .c2h_word(c2h_word), .status(status),
    .four_byte_on(four_byte_on));
`default_nettype wire

// file: test/aecd_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module aecd_host_model
    import aecd_pkg::*;
(
    input  wire logic      clock,     // Clock.
    output var aecd_host_req_t host_req, // Host access.
    input  wire logic [7:0] host_rdata // Read data.
);
    initial host_req = '0;
    // One access; idle strobes are low, idle address and data lines carry the inverse of the last request.
    task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(negedge clock);
        host_req = '{w, !w, a, d};
        @(posedge clock);
        q = host_rdata;
        @(negedge clock);
        host_req = '{1'b0, 1'b0, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import aecd_pkg::*;
;
    logic clock = 0, sys_rst = 1, espi_mode = 0, fbm = 0;
    aecd_ctl_req_t ctl_req = '0;
    aecd_host_req_t host_req;
    logic [7:0] host_rdata, status, q;
    logic [31:0] h2c_word, c2h_word;
    logic four_byte_on;
    int errors = 0, comparisons = 0;
    always #10 clock = ~clock;
    aecd_host_model hm (.clock(clock), .host_req(host_req), .host_rdata(host_rdata));
    aecd_host_port #(.INSTANCE_ZERO(1'b1)) uut (.clock(clock), .sys_rst(sys_rst),
        .host_req(host_req), .host_rdata(host_rdata), .espi_mode(espi_mode),
        .ctl_req(ctl_req), .h2c_word(h2c_word), .c2h_word(c2h_word), .status(status),
        .four_byte_on(four_byte_on));
    // =====
    // Helpers.
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic ctl(logic dw, logic [1:0] di, logic [7:0] dv, logic sw, logic [7:0] sv,
                       logic ic);
        @(negedge clock);
        ctl_req = '{dw, di, dv, sw, sv, ic, fbm};
        @(negedge clock);
        ctl_req = '{1'b0, 2'h0, 8'h00, 1'b0, 8'h00, 1'b0, fbm};
    endtask
    task automatic stop_test;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // =====
    // Scenarios.
    task automatic t_reset;
        chk(status, 0);
        chk(h2c_word, 0);
        for (int i = 0; i < 4; i++) begin
            hm.access(0, i[2:0], 8'h00, q);
            chk(q, 0);
        end
    endtask
    task automatic t_cmd;
        hm.access(1, 3'h4, 8'ha5, q);
        chk({status[3], status[1], h2c_word[7:0]}, 10'h3a5);
        hm.access(1, 3'h0, 8'h3c, q);
        chk({status[3], h2c_word[7:0]}, 9'h03c);
        ctl(0, 0, 0, 0, 0, 1);
        chk(status[1], 0);
    endtask
    task automatic t_legacy;
        for (int i = 0; i < 4; i++) ctl(1, i[1:0], 8'(8'h11 * (i + 1)), 0, 0, 0);
        chk({c2h_word, status[0]}, 33'h088664423);
        for (int i = 1; i < 4; i++) begin
            hm.access(1, i[2:0], 8'hee, q);
            hm.access(0, i[2:0], 8'h00, q);
            chk(q, 0);
        end
        chk({h2c_word[31:8], status[1:0]}, 26'h1);
        hm.access(0, 3'h0, 8'h00, q);
        chk({q, status[0]}, 9'h022);
        hm.access(1, 3'h0, 8'h5a, q);
        chk(status[1], 1);
        ctl(0, 0, 0, 0, 0, 1);
    endtask
    task automatic t_four;
        fbm = 1;
        ctl(0, 0, 0, 0, 0, 0);
        chk(four_byte_on, 1);
        hm.access(0, 3'h5, 8'h00, q);
        chk(q, 1);
        for (int i = 0; i < 4; i++) begin
            hm.access(1, i[2:0], 8'(8'h10 + i), q);
            chk(status[1], i == 3);
        end
        chk(h2c_word, 32'h13121110);
        ctl(0, 0, 0, 0, 0, 1);
        for (int i = 0; i < 4; i++) begin
            ctl(1, i[1:0], 8'h20 + i, 0, 0, 0);
            chk(status[0], i == 3);
        end
        for (int i = 0; i < 4; i++) begin
            hm.access(0, i[2:0], 8'h00, q);
            chk({q, status[0]}, {8'(8'h20 + i), i != 3});
        end
    endtask
    task automatic t_espi;
        espi_mode = 1;
        @(negedge clock);
        chk(four_byte_on, 0);
        hm.access(0, 3'h5, 8'h00, q);
        chk(q, 0);
        hm.access(1, 3'h0, 8'h77, q);
        chk(status[1], 1);
        fbm = 0;
        ctl(0, 0, 0, 1, 8'h60, 0);
        chk(status, 8'h60);
        hm.access(0, 3'h4, 8'h00, q);
        chk(q, 8'h60);
        hm.access(0, 3'h7, 8'h00, q);
        chk(q, 0);
    endtask
    task automatic t_rerun;
        @(negedge clock);
        sys_rst = 1;
        repeat (2) @(negedge clock);
        sys_rst = 0;
        chk({status, four_byte_on}, 0);
        chk(h2c_word | c2h_word, 0);
    endtask
    initial begin
        repeat (2) @(negedge clock);
        sys_rst = 0;
        t_reset();
        t_cmd();
        t_legacy();
        t_four();
        t_espi();
        t_rerun();
        stop_test();
    end
    initial begin
        #100us;
        errors++;
        stop_test();
    end
endmodule
`default_nettype wire
